// [hdl/scm_calib.v]
// Calibration mode logic of the photoelectric smoke detector
`timescale 1ns/1ns
`default_nettype none
`include "scm_defs.vh"

module scm_calib (
	input  wire        ref_clk,
	input  wire        reset_n,
	// Wishbone classic slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output wire        wb_ack_o,
	output wire        wb_err_o,
	// Pins
	input  wire        test_sink,
	input  wire        oscillator_input,
	input  wire        io_in,
	output wire        io_out,
	output wire        io_oe,
	input  wire        supply_trip,
	input  wire        hyst_ctrl,
	input  wire        amp_pulse,
	input  wire        smoke_detect,
	output reg         horn1_reg,
	output reg         horn2_reg,
	output reg         infrared_emitter_pulse,
	output reg         strobe_n_reg,
	output reg         comp_mon_reg,
	output wire        integ_mon,
	output reg         sup_gain_reg,
	output reg         hyst_gain_reg,
	output reg         lowsup_check_reg,
	output reg         superv_check_reg
);

	// ********************************
	// Pin synchronisers
	// ********************************
	reg [4:0] sync1_reg;
	reg [4:0] sync2_reg;
	wire      sink_s  = sync2_reg[0];
	wire      osc_s   = sync2_reg[1];
	wire      io_s    = sync2_reg[2];
	wire      trip_s  = sync2_reg[3];
	wire      hyst_s  = sync2_reg[4];
	reg       amp1_reg;
	reg       amp2_reg;
	reg       det1_reg;
	reg       det2_reg;

	// Two flops on every pin input before any logic sees it
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_reg <= 5'h00;
			sync2_reg <= 5'h00;
			amp1_reg  <= 1'b0;
			amp2_reg  <= 1'b0;
			det1_reg  <= 1'b0;
			det2_reg  <= 1'b0;
		end else begin
			sync1_reg <= {hyst_ctrl, supply_trip, io_in, oscillator_input, test_sink};
			sync2_reg <= sync1_reg;
			amp1_reg  <= amp_pulse;
			amp2_reg  <= amp1_reg;
			det1_reg  <= smoke_detect;
			det2_reg  <= det1_reg;
		end
	end

	// ********************************
	// Internal clock
	// ********************************
	reg  osc_prev_reg;
	// level follows pin
	// Same level whether driven or free-running, so no separate path
	wire int_clk   = osc_s;
	wire osc_rise  = int_clk && !osc_prev_reg;
	wire osc_fall  = !int_clk && osc_prev_reg;

	// Last level; resets to the idle low of the pin so no false edge follows
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			osc_prev_reg <= 1'b0;
		else
			osc_prev_reg <= int_clk;
	end

	// ********************************
	// Mode entry and exit
	// ********************************
	reg       cal_reg;
	reg       cal_next;
	reg [1:0] hold_reg;
	reg [1:0] hold_next;

	// entry after a full oscillator cycle of sinking
	// exit after a full oscillator cycle floating
	// Qualified on rising edges so a glitch shorter than a cycle is ignored
	always @* begin
		cal_next  = cal_reg;
		hold_next = hold_reg;
		if (sink_s == cal_reg) begin
			hold_next = 2'h0;
		end else if (osc_rise) begin
			if (hold_reg == `SCM_ENTRY_CYCLES) begin
				cal_next  = sink_s;
				hold_next = 2'h0;
			end else begin
				hold_next = hold_reg + 2'h1;
			end
		end
	end

	// Mode state; reset leaves the block out of calibration
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cal_reg  <= 1'b0;
			hold_reg <= 2'h0;
		end else begin
			cal_reg  <= cal_next;
			hold_reg <= hold_next;
		end
	end

	// ********************************
	// Software registers
	// ********************************
	reg  [1:0]  ctrl_reg;
	reg  [15:0] standby_reg;
	reg  [15:0] samples_reg;
	reg         ack_reg;
	wire        req      = wb_cyc_i && wb_stb_i;
	wire        hit_ctrl = (wb_adr_i == `SCM_ADDR_CTRL);
	wire        hit_stb  = (wb_adr_i == `SCM_ADDR_STANDBY);
	reg         mapped;

	// Address decode
	always @* begin
		if (wb_adr_i == `SCM_ADDR_CTRL)
			mapped = 1'b1;
		else if (wb_adr_i == `SCM_ADDR_STATUS)
			mapped = 1'b1;
		else if (wb_adr_i == `SCM_ADDR_STANDBY)
			mapped = 1'b1;
		else if (wb_adr_i == `SCM_ADDR_SAMPLES)
			mapped = 1'b1;
		else
			mapped = 1'b0;
	end

	// One wait state; ack drops the cycle after it was given
	assign wb_ack_o = ack_reg && mapped;
	assign wb_err_o = ack_reg && !mapped;

	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ack_reg     <= 1'b0;
			ctrl_reg    <= `SCM_CTRL_RESET;
			standby_reg <= `SCM_STANDBY_RESET;
		end else begin
			ack_reg <= req && !ack_reg;
			// Writes land on the edge where the master samples ack
			if (req && ack_reg && wb_we_i) begin
				if (hit_ctrl) begin
					if (wb_sel_i[0])
						ctrl_reg <= wb_dat_i[1:0];
				end else if (hit_stb) begin
					if (wb_sel_i[0])
						standby_reg[7:0] <= wb_dat_i[7:0];
					if (wb_sel_i[1])
						standby_reg[15:8] <= wb_dat_i[15:8];
				end
			end
		end
	end

	reg [31:0] status_word;

	// Status bits placed by field position, so the map lives in one header
	always @* begin
		status_word                  = 32'h0000_0000;
		status_word[`SCM_ST_CAL]     = cal_reg;
		status_word[`SCM_ST_COMP]    = comp_mon_reg;
		status_word[`SCM_ST_INTEG]   = integ_mon;
		status_word[`SCM_ST_SUPGAIN] = sup_gain_reg;
		status_word[`SCM_ST_HYST]    = hyst_gain_reg;
		status_word[`SCM_ST_ROUTE]   = io_s && cal_reg;
	end

	// Read data registered with the ack
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (req && !ack_reg && !wb_we_i) begin
			if (wb_adr_i == `SCM_ADDR_CTRL)
				wb_dat_o <= {30'h0, ctrl_reg};
			else if (wb_adr_i == `SCM_ADDR_STATUS)
				wb_dat_o <= status_word;
			else if (wb_adr_i == `SCM_ADDR_STANDBY)
				wb_dat_o <= {16'h0, standby_reg};
			else if (wb_adr_i == `SCM_ADDR_SAMPLES)
				wb_dat_o <= {16'h0, samples_reg};
			else
				wb_dat_o <= 32'h0000_0000;
		end
	end

	// ********************************
	// Emitter timing
	// ********************************
	reg [15:0] intv_reg;
	reg [7:0]  chk_reg;

	// pulse each internal clock in calibration
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			intv_reg               <= 16'h0000;
			infrared_emitter_pulse <= 1'b0;
		end else if (cal_reg) begin
			intv_reg               <= 16'h0000;
			infrared_emitter_pulse <= osc_rise;
		end else if (osc_rise) begin
			if (intv_reg >= standby_reg - 16'h0001) begin
				intv_reg               <= 16'h0000;
				infrared_emitter_pulse <= 1'b1;
			end else begin
				intv_reg               <= intv_reg + 16'h0001;
				infrared_emitter_pulse <= 1'b0;
			end
		end else begin
			infrared_emitter_pulse <= 1'b0;
		end
	end

	// periodic checks gated off in calibration
	// Checks count emitter pulses only while cal_reg is low, so they can never fire in calibration
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			chk_reg          <= 8'h00;
			lowsup_check_reg <= 1'b0;
			superv_check_reg <= 1'b0;
		end else begin
			lowsup_check_reg <= 1'b0;
			superv_check_reg <= 1'b0;
			if (cal_reg) begin
				chk_reg <= 8'h00;
			end else if (infrared_emitter_pulse) begin
				if (chk_reg == `SCM_CHECK_PERIOD - 8'h01) begin
					chk_reg          <= 8'h00;
					lowsup_check_reg <= ctrl_reg[`SCM_CTRL_LOWSUP_EN];
					superv_check_reg <= ctrl_reg[`SCM_CTRL_SUPERV_EN];
				end else begin
					chk_reg <= chk_reg + 8'h01;
				end
			end
		end
	end

	// ********************************
	// Strobe, gain and routing
	// ********************************
	// strobe held low in calibration
	// amp pulses to horn pins with interconnect high
	// supply trip picks gain and horn
	// hysteresis only with supply trip low
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			strobe_n_reg  <= 1'b1;
			horn1_reg     <= 1'b0;
			horn2_reg     <= 1'b0;
			sup_gain_reg  <= 1'b0;
			hyst_gain_reg <= 1'b0;
		end else if (cal_reg) begin
			strobe_n_reg  <= 1'b0;
			horn1_reg     <= io_s && !trip_s && amp2_reg;
			horn2_reg     <= io_s && trip_s && amp2_reg;
			sup_gain_reg  <= io_s && trip_s;
			hyst_gain_reg <= hyst_s && !trip_s;
		end else begin
			// Normal sequencing lives elsewhere; strobe pulses low the clock after each emitter pulse, other outputs rest idle here
			strobe_n_reg  <= !infrared_emitter_pulse;
			horn1_reg     <= 1'b0;
			horn2_reg     <= 1'b0;
			sup_gain_reg  <= 1'b0;
			hyst_gain_reg <= 1'b0;
		end
	end

	// interconnect never driven by this block
	assign io_out = 1'b0;
	assign io_oe  = 1'b0;

	// ********************************
	// Smoke monitors
	// ********************************
	// Sample at the clock fall, after the comparator had its high phase
	wire       sample = cal_reg && osc_fall;

	// positive pulse while clock high on detecting sample
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			comp_mon_reg <= 1'b0;
		else if (!cal_reg || osc_fall)
			comp_mon_reg <= 1'b0;
		else if (osc_rise)
			comp_mon_reg <= det2_reg;
	end

	// Count detecting samples for software
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			samples_reg <= 16'h0000;
		else if (sample && comp_mon_reg)
			samples_reg <= samples_reg + 16'h0001;
	end

	scm_sample_hist u_hist (
		.ref_clk    (ref_clk),
		.reset_n    (reset_n),
		.sample_stb (sample),
		.detect     (comp_mon_reg),
		.clear      (!cal_reg),
		.integ_reg  (integ_mon),
		.hist_reg   ()
	);

endmodule
`default_nettype wire

// [hdl/scm_sample_hist.v]
// Two-deep detection history and smoke integrator
`timescale 1ns/1ns
`default_nettype none

module scm_sample_hist (
	input  wire       ref_clk,
	input  wire       reset_n,
	input  wire       sample_stb,
	input  wire       detect,
	input  wire       clear,
	output reg        integ_reg,
	output reg  [1:0] hist_reg
);

	// ********************************
	// Integrator
	// ********************************
	// On with two hits, off with two misses; a single odd sample holds the level
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			hist_reg  <= 2'h0;
			integ_reg <= 1'b0;
		end else if (clear) begin
			hist_reg  <= 2'h0;
			integ_reg <= 1'b0;
		end else if (sample_stb) begin
			hist_reg <= {hist_reg[0], detect};
			if (hist_reg[0] && detect)
				integ_reg <= 1'b1;
			else if (!hist_reg[0] && !detect)
				integ_reg <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// [inc/scm_defs.vh]
// Constants for the smoke calibration mode block
`ifndef SCM_DEFS_VH
`define SCM_DEFS_VH

// ********************************
// Register map (word byte addresses)
// ********************************
`define SCM_ADDR_CTRL        8'h00
`define SCM_ADDR_STATUS      8'h04
`define SCM_ADDR_STANDBY     8'h08
`define SCM_ADDR_SAMPLES     8'h0C

// ********************************
// Control register fields
// ********************************
`define SCM_CTRL_LOWSUP_EN   0
`define SCM_CTRL_SUPERV_EN   1
`define SCM_CTRL_RESET       2'h3

// ********************************
// Status register fields
// ********************************
`define SCM_ST_CAL           0
`define SCM_ST_COMP          1
`define SCM_ST_INTEG         2
`define SCM_ST_SUPGAIN       3
`define SCM_ST_HYST          4
`define SCM_ST_ROUTE         5

// ********************************
// Timing
// ********************************
// Standby emitter interval in oscillator cycles
`define SCM_STANDBY_RESET    16'h0010
// Oscillator cycles the manual-test level must hold
`define SCM_ENTRY_CYCLES     2'h1
`define SCM_CHECK_PERIOD     8'h20

`endif

// [test/scm_calib_monitor.sv]
// Concurrent checks on the calibration block ports
`timescale 1ns/1ns
`default_nettype none
module scm_calib_monitor (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic io_oe,
	input wire logic io_in,
	input wire logic supply_trip,
	input wire logic amp_pulse,
	input wire logic smoke_detect,
	input wire logic oscillator_input,
	input wire logic horn1_reg,
	input wire logic horn2_reg,
	input wire logic infrared_emitter_pulse,
	input wire logic strobe_n_reg,
	input wire logic comp_mon_reg,
	input wire logic integ_mon,
	input wire logic sup_gain_reg,
	input wire logic hyst_gain_reg,
	input wire logic lowsup_check_reg,
	input wire logic superv_check_reg
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// Pin behaviour in calibration
	chk_io_released: assert property (!io_oe)
		else $error("interconnect driven");
	chk_horn_exclusive: assert property (!(horn1_reg && horn2_reg))
		else $error("both horn pins active");
	chk_horn1_route: assert property (horn1_reg |->
		$past(io_in, 3) && !$past(supply_trip, 3) && $past(amp_pulse, 3))
		else $error("first horn pin without cause");
	chk_horn2_route: assert property (horn2_reg |->
		$past(io_in, 3) && $past(supply_trip, 3) && $past(amp_pulse, 3))
		else $error("second horn pin without cause");
	chk_hyst_low_trip: assert property (hyst_gain_reg |-> !sup_gain_reg)
		else $error("hysteresis with supervisory gain");
	chk_checks_held: assert property ((!strobe_n_reg) [*3] |->
		!lowsup_check_reg && !superv_check_reg)
		else $error("check pulse while strobe held");
	chk_emit_single: assert property (infrared_emitter_pulse |=>
		!infrared_emitter_pulse)
		else $error("emitter pulse too long");
	chk_emit_on_osc: assert property (infrared_emitter_pulse |->
		$past(oscillator_input, 2))
		else $error("emitter pulse outside clock high");
	chk_comp_cause: assert property ($rose(comp_mon_reg) |->
		$past(smoke_detect, 2))
		else $error("comparator monitor without smoke");
	cover property (horn1_reg);
	cover property (horn2_reg);
	cover property ($rose(integ_mon));
	cover property (hyst_gain_reg);
endmodule
bind scm_calib scm_calib_monitor i_scm_calib_monitor (
	.ref_clk                (ref_clk),
	.reset_n                (reset_n),
	.io_oe                  (io_oe),
	.io_in                  (io_in),
	.supply_trip            (supply_trip),
	.amp_pulse              (amp_pulse),
	.smoke_detect           (smoke_detect),
	.oscillator_input       (oscillator_input),
	.horn1_reg              (horn1_reg),
	.horn2_reg              (horn2_reg),
	.infrared_emitter_pulse (infrared_emitter_pulse),
	.strobe_n_reg           (strobe_n_reg),
	.comp_mon_reg           (comp_mon_reg),
	.integ_mon              (integ_mon),
	.sup_gain_reg           (sup_gain_reg),
	.hyst_gain_reg          (hyst_gain_reg),
	.lowsup_check_reg       (lowsup_check_reg),
	.superv_check_reg       (superv_check_reg)
);
`default_nettype wire

// [test/scm_fixture.sv]
// Calibration fixture model driving the reconfigured pins
`timescale 1ns/1ns
`default_nettype none
module scm_fixture #(parameter int HALF = 24) (
	input  wire logic ref_clk,
	input  wire logic sink_cmd,
	output var  logic test_sink,
	output var  logic oscillator_input,
	output var  logic amp_pulse
);
	int   cnt = 0;
	logic osc_q = 1'b0;
	logic sink_q = 1'b0;
	logic amp_q = 1'b0;
	// One driver per pin, each from its own register
	assign oscillator_input = osc_q;
	assign test_sink = sink_q;
	assign amp_pulse = amp_q;
	// network left intact
	// Free-running clock, slow enough for the pin synchronisers
	always @(posedge ref_clk) begin
		cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
		if (cnt == HALF - 1)
			osc_q <= ~osc_q;
		amp_q <= cnt[1];
	end
	// sink or float
	// Bench gives one 10-clock glitch; its other commands span whole oscillator cycles
	always @(posedge ref_clk)
		sink_q <= sink_cmd;
endmodule
`default_nettype wire

// [test/smoke_calibration_mode_test.sv]
// Self-checking bench for the calibration block
`timescale 1ns/1ns
`default_nettype none
`include "scm_defs.vh"
module smoke_calibration_mode_test;
	logic        ref_clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, sink_cmd, s, prev, integ;
	logic        io_in, supply_trip, hyst_ctrl, smoke_detect, test_sink, amp_pulse;
	logic        oscillator_input;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i;
	logic [64:0] e;
	logic [64:0] exp_q[$];
	wire  [31:0] wb_dat_o;
	wire         wb_ack_o, wb_err_o, io_out, io_oe, horn1_reg, horn2_reg, strobe_n_reg;
	wire         infrared_emitter_pulse, comp_mon_reg, integ_mon, sup_gain_reg;
	wire         hyst_gain_reg, lowsup_check_reg, superv_check_reg;
	int          n_mismatch = 0;
	int          compares = 0;
	int          seed = 32'h07275552;
	int          n_det = 0;
	int          n_wait;
	scm_calib i_scm_calib (.*);
	scm_fixture i_scm_fixture (.*);
	always #2 ref_clk = ~ref_clk;
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s exp %h seen %h", name, exp, seen);
		end
	endtask
	task stop_test;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Classic cycle held until the answer is sampled
	task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_adr_i <= a;
		wb_we_i <= w;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
		if (n >= 20) begin
			n_mismatch++;
			stop_test;
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic er, input logic [31:0] m, input logic [31:0] v);
		exp_q.push_back({er, m, v});
		bus(a, 1'b0, 32'h0);
	endtask
	task st(input logic [31:0] v, input logic [31:0] m);
		rd(`SCM_ADDR_STATUS, 1'b0, m, v);
	endtask
	// Settle six reference clocks into an oscillator phase
	task ph(input logic lvl);
		if (lvl)
			@(posedge oscillator_input);
		else
			@(negedge oscillator_input);
		repeat (6) @(posedge ref_clk);
	endtask
	// Oldest note is matched against each read answer
	always @(posedge ref_clk) begin
		if ((wb_ack_o | wb_err_o) && !wb_we_i && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			chk("err", {31'h0, wb_err_o}, {31'h0, e[64]});
			chk("data", wb_dat_o & e[63:32], e[31:0]);
		end
	end
	// Hang guard
	initial begin
		#40000;
		n_mismatch++;
		stop_test;
	end
	// ****************
	// Main sequence
	// ****************
	initial begin
		{ref_clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, sink_cmd} = 6'h0;
		{io_in, supply_trip, hyst_ctrl, smoke_detect, wb_adr_i} = 12'h0;
		{wb_sel_i, wb_dat_i} = {4'hF, 32'h0};
		repeat (5) @(posedge ref_clk);
		reset_n <= 1'b1;
		rd(`SCM_ADDR_CTRL, 1'b0, 32'h3, 32'h3);
		rd(`SCM_ADDR_STANDBY, 1'b0, 32'hFFFF, 32'h10);
		bus(`SCM_ADDR_CTRL, 1'b1, 32'h0);
		rd(`SCM_ADDR_CTRL, 1'b0, 32'h3, 32'h0);
		bus(`SCM_ADDR_CTRL, 1'b1, 32'h3);
		bus(`SCM_ADDR_STATUS, 1'b1, 32'hFFFFFFFF);
		rd(8'h10, 1'b1, 32'h0, 32'h0);
		st(32'h0, 32'h1);
		sink_cmd <= 1'b1;
		repeat (10) @(posedge ref_clk);
		sink_cmd <= 1'b0;
		repeat (60) @(posedge ref_clk);
		st(32'h0, 32'h1);
		io_in <= 1'b1;
		sink_cmd <= 1'b1;
		repeat (110) @(posedge ref_clk);
		ph(1'b0);
		st(32'h21, 32'h39);
		chk("strobe", {31'h0, strobe_n_reg}, 32'h0);
		for (int i = 0; i < 4; i++) begin
			{supply_trip, hyst_ctrl} <= i[1:0];
			ph(1'b0);
			st({26'h0, 1'b1, i[0] & ~i[1], i[1], 3'h1}, 32'h39);
		end
		{io_in, supply_trip, hyst_ctrl} <= 3'h0;
		ph(1'b0);
		ph(1'b0);
		st(32'h1, 32'h3F);
		prev = 1'b0;
		integ = 1'b0;
		for (int k = 0; k < 12; k++) begin
			s = $random(seed);
			smoke_detect <= s;
			ph(1'b1);
			st({30'h0, s, 1'b1}, 32'h3);
			if (s)
				n_det++;
			if (s == prev)
				integ = s;
			prev = s;
			ph(1'b0);
			st({29'h0, integ, 2'h1}, 32'h7);
		end
		rd(`SCM_ADDR_SAMPLES, 1'b0, 32'hFFFF, n_det);
		{io_in, hyst_ctrl} <= 2'h3;
		sink_cmd <= 1'b0;
		repeat (110) @(posedge ref_clk);
		st(32'h0, 32'h31);
		// Fast standby with only the low-supply check enabled
		bus(`SCM_ADDR_STANDBY, 1'b1, 32'h1);
		bus(`SCM_ADDR_CTRL, 1'b1, 32'h1);
		rd(`SCM_ADDR_STANDBY, 1'b0, 32'hFFFF, 32'h1);
		n_wait = 0;
		while (lowsup_check_reg !== 1'b1 && superv_check_reg !== 1'b1 && n_wait < 2000) begin
			@(posedge ref_clk);
			n_wait++;
		end
		chk("lowsup", {31'h0, lowsup_check_reg}, 32'h1);
		chk("superv", {31'h0, superv_check_reg}, 32'h0);
		stop_test;
	end
endmodule
`default_nettype wire
